// >>> ribp_top.sv
// Local design decisions: the register offsets and the APB register port.
`default_nettype none

// Summary of operation
// - shared timer pins select timer after reset
// - each port pin individually input or output
// - pin pull-ups on at reset, bit clear disables
// - stop or wait: irq wake recognised asynchronously
// - other modes: irq inputs synchronised to clock
// - each irq programmable level or falling edge
// - irq pull-up on at reset, disable bit
// - reset input low initialises and holds device
// - internal reset released synchronously after fixed count
// - power-on reset asserts device reset independently
// - reset pull-up on at reset, disable bit
// - reset output mirrors internal reset state
// - boot strap high boots external unless secured
// - both straps tied low internally
// - boot decision uses strap, security, memory mode
// - secured flash forces internal boot mode 00
module ribp_top #(
    parameter int unsigned RELEASE_CYCLES = ribp_pkg::RELEASE_CYCLES_DEF
) (
    // clock and resets
    input  wire logic                       clk_sys_in,
    input  wire logic                       reset_n_in,
    input  wire logic                       por_n_in,
    // apb slave
    input  wire logic                       psel_in,
    input  wire logic                       penable_in,
    input  wire logic                       pwrite_in,
    input  wire logic [ribp_pkg::APB_AW-1:0] paddr_in,
    input  wire logic [ribp_pkg::APB_DW-1:0] pwdata_in,
    output logic      [ribp_pkg::APB_DW-1:0] prdata_out,
    output logic                            pready_out,
    output logic                            pslverr_out,
    // reset outputs
    output logic                            reset_out_n_out,
    output logic                            sys_reset_n_out,
    // interrupt pins and core side
    input  wire logic                       ext_irq_a_n_in,
    input  wire logic                       ext_irq_b_n_in,
    input  wire logic                       low_power_in,
    output logic      [ribp_pkg::IRQ_N-1:0] irq_req_out,
    output logic                            irq_wake_out,
    // boot
    input  wire logic                       flash_secured_in,
    output logic      [1:0]                 boot_mode_out,
    output logic                            ext_mem_mode_out,
    // pull-up enables
    output logic                            irq_pullup_en_out,
    output logic                            reset_pullup_en_out,
    output logic                            boot_strap_pullup_en_out,
    output logic                            mem_mode_pullup_en_out,
    output logic      [ribp_pkg::PE_N-1:0]  port_e_pullup_en_out,
    // timer side of the shared pins
    input  wire logic [ribp_pkg::PE_N-1:0]  timer_d_out_in,
    input  wire logic [ribp_pkg::PE_N-1:0]  timer_d_oe_in,
    output logic      [ribp_pkg::PE_N-1:0]  timer_d_in_out,
    // shared pins, port_e_pin_10 .. port_e_pin_13
    input  wire logic [ribp_pkg::PE_N-1:0]  timer_d_channel_pins_in,
    output logic      [ribp_pkg::PE_N-1:0]  timer_d_channel_pins_out,
    output logic      [ribp_pkg::PE_N-1:0]  timer_d_channel_pins_oe_out
);
    import ribp_pkg::*;

    localparam int unsigned CNT_W = $clog2(RELEASE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(RELEASE_CYCLES - 1);

    // elaboration check on the release count
    generate
        if (RELEASE_CYCLES < 1)
        begin : g_bad_count
            $error("RELEASE_CYCLES must be at least 1");
        end
    endgenerate

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    logic            raw_rst_n;      // pin reset and power-on combined
    ribp_rst_state_t rst_state_reg;
    ribp_rst_state_t rst_state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic            int_rst_n_reg;  // internal reset, active low
    logic            cnt_done;

    // either source drives the device into reset
    assign raw_rst_n = reset_n_in & por_n_in;
    assign cnt_done  = (cnt_reg == CNT_LAST);

    // next state of the release counter
    always_comb
    begin
        rst_state_next = rst_state_reg;
        cnt_next       = cnt_reg;
        unique case (rst_state_reg)
            RST_COUNT:
            begin
                if (cnt_done)
                    rst_state_next = RST_DONE;
                else
                    cnt_next = cnt_reg + CNT_W'(1);
            end
            RST_DONE:
            begin
                cnt_next = cnt_reg;
            end
        endcase
    end

    // asynchronous assert, synchronous release
    always_ff @(posedge clk_sys_in or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
        begin
            rst_state_reg <= RST_COUNT;
            cnt_reg       <= '0;
            int_rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_state_reg <= rst_state_next;
            cnt_reg       <= cnt_next;
            int_rst_n_reg <= (rst_state_next == RST_DONE);
        end
    end

    // reset pin and core reset follow the internal state
    assign reset_out_n_out = int_rst_n_reg;
    assign sys_reset_n_out = int_rst_n_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [DEC_W-1:0] addr;
    logic             hit_pud;
    logic             hit_pur;
    logic             hit_func;
    logic             hit_dir;
    logic             hit_data;
    logic             hit_ictl;
    logic             hit_stat;
    logic             hit_any;
    logic             access;
    logic             wr_en;     // write strobe, blocked in reset
    logic             setup;

    assign addr     = paddr_in[DEC_W-1:0];
    assign hit_pud  = (addr == OFS_PULLUP_DIS);
    assign hit_pur  = (addr == OFS_PE_PULLUP);
    assign hit_func = (addr == OFS_PE_FUNC);
    assign hit_dir  = (addr == OFS_PE_DIR);
    assign hit_data = (addr == OFS_PE_DATA);
    assign hit_ictl = (addr == OFS_IRQ_CTRL);
    assign hit_stat = (addr == OFS_STATUS);
    assign hit_any  = (paddr_in[APB_AW-1:DEC_W] == '0)
                    & (hit_pud | hit_pur | hit_func | hit_dir
                       | hit_data | hit_ictl | hit_stat);
    assign setup    = psel_in & ~penable_in;
    assign access   = psel_in & penable_in;
    assign wr_en    = access & pwrite_in & hit_any & int_rst_n_reg;

    // zero wait states; unmapped addresses answer with an error
    assign pready_out  = 1'b1;
    assign pslverr_out = access & ~hit_any;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [PUD_W-1:0] pud_reg;    // pullup_disable_reg
    logic [PE_N-1:0]  pur_reg;    // port_e_pullup_enable
    logic [PE_N-1:0]  func_reg;   // port function select
    logic [PE_N-1:0]  dir_reg;    // port direction
    logic [PE_N-1:0]  data_reg;   // port output latch
    logic [IRQ_N-1:0] ictl_reg;   // irq edge select
    logic [APB_DW-1:0] rdata_reg; // read data, taken in setup
    logic [APB_DW-1:0] rd_mux;
    logic [ST_W-1:0]  status;

    // software registers, reset values select timer use
    always_ff @(posedge clk_sys_in or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
        begin
            pud_reg  <= PUD_RST;
            pur_reg  <= PE_PULLUP_RST;
            func_reg <= PE_FUNC_RST;
            dir_reg  <= PE_DIR_RST;
            data_reg <= PE_DATA_RST;
            ictl_reg <= IRQ_CTRL_RST;
        end
        else if (wr_en)
        begin
            if (hit_pud)
                pud_reg <= pwdata_in[PUD_W-1:0];
            if (hit_pur)
                pur_reg <= pwdata_in[PE_N-1:0];
            if (hit_func)
                func_reg <= pwdata_in[PE_N-1:0];
            if (hit_dir)
                dir_reg <= pwdata_in[PE_N-1:0];
            if (hit_data)
                data_reg <= pwdata_in[PE_N-1:0];
            if (hit_ictl)
                ictl_reg <= pwdata_in[IRQ_N-1:0];
        end
    end

    // read multiplexer; data register reads the pins
    always_comb
    begin
        rd_mux = '0;
        if (hit_pud)
            rd_mux = APB_DW'(pud_reg);
        else if (hit_pur)
            rd_mux = APB_DW'(pur_reg);
        else if (hit_func)
            rd_mux = APB_DW'(func_reg);
        else if (hit_dir)
            rd_mux = APB_DW'(dir_reg);
        else if (hit_data)
            rd_mux = APB_DW'(timer_d_channel_pins_in);
        else if (hit_ictl)
            rd_mux = APB_DW'(ictl_reg);
        else if (hit_stat)
            rd_mux = APB_DW'(status);
    end

    // read data captured in the setup cycle
    always_ff @(posedge clk_sys_in or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
            rdata_reg <= '0;
        else if (setup)
            rdata_reg <= hit_any ? rd_mux : '0;
    end

    assign prdata_out = rdata_reg;

    // ------------------------------------------------------------
    // external interrupts
    // ------------------------------------------------------------
    logic [IRQ_N-1:0] irq_pins_n;
    logic [IRQ_N-1:0] irq_pend;
    logic             stat_wr;

    ribp_irq_if irq_bus [IRQ_N] ();

    assign irq_pins_n = {ext_irq_b_n_in, ext_irq_a_n_in};
    assign stat_wr    = wr_en & hit_stat;

    // one channel per request input
    for (genvar i = 0; i < IRQ_N; i++)
    begin : g_irq
        assign irq_bus[i].edge_sel = ictl_reg[i];
        // write one to clear a pending flag
        assign irq_bus[i].clear    = stat_wr & pwdata_in[ST_PEND_LSB + i];
        assign irq_pend[i]         = irq_bus[i].pending;
        assign irq_req_out[i]      = irq_bus[i].request;

        ribp_irq_chan u_chan (
            .clk_in   (clk_sys_in),
            .rst_n_in (raw_rst_n),
            .irq_n_in (irq_pins_n[i]),
            .ctl      (irq_bus[i])
        );
    end

    // clockless wake path for stop and wait
    assign irq_wake_out = low_power_in & ~(&irq_pins_n);

    // ------------------------------------------------------------
    // boot configuration
    // ------------------------------------------------------------
    logic [1:0] boot_reg;    // {mb, ma}
    logic       memmd_reg;
    logic       boot_ma;
    logic       boot_mb;

    // straps tied low inside the device
    // external boot only with unsecured flash
    assign boot_mb = ~flash_secured_in;
    assign boot_ma = EXT_BOOT_TIE & ~flash_secured_in;

    // latched while the internal reset is held
    always_ff @(posedge clk_sys_in or negedge raw_rst_n)
    begin
        if (!raw_rst_n)
        begin
            boot_reg  <= BOOT_RST;
            memmd_reg <= 1'b0;
        end
        else if (!int_rst_n_reg)
        begin
            boot_reg  <= {boot_mb, boot_ma};
            memmd_reg <= boot_ma & MEMMD_TIE;
        end
    end

    assign boot_mode_out    = boot_reg;
    assign ext_mem_mode_out = memmd_reg;
    assign status           = {memmd_reg, boot_reg, irq_pend};

    // ------------------------------------------------------------
    // pull-ups and shared pins
    // ------------------------------------------------------------
    assign irq_pullup_en_out        = ~pud_reg[PUD_IRQ_BIT];
    assign reset_pullup_en_out      = ~pud_reg[PUD_RESET_BIT];
    assign boot_strap_pullup_en_out = ~pud_reg[PUD_BOOT_BIT];
    assign mem_mode_pullup_en_out   = ~pud_reg[PUD_MEMMD_BIT];
    assign port_e_pullup_en_out     = pur_reg;

    // timer or port drives each pin
    assign timer_d_channel_pins_out =
        (func_reg & data_reg) | (~func_reg & timer_d_out_in);
    assign timer_d_channel_pins_oe_out =
        (func_reg & dir_reg) | (~func_reg & timer_d_oe_in);
    assign timer_d_in_out = timer_d_channel_pins_in;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_rst_release: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        $rose(int_rst_n_reg) |-> $past(cnt_reg) == CNT_LAST)
        else $error("internal reset released at wrong count");

    a_rst_mirror: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        !int_rst_n_reg |-> !reset_out_n_out && !sys_reset_n_out)
        else $error("reset output does not follow internal reset");

    a_timer_default: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        !int_rst_n_reg |->
            timer_d_channel_pins_oe_out == timer_d_oe_in)
        else $error("shared pins not on timer during reset");

    a_pullup_reset: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        !int_rst_n_reg |-> port_e_pullup_en_out == PE_PULLUP_RST
            && irq_pullup_en_out && reset_pullup_en_out)
        else $error("pull-ups not enabled during reset");

    a_secure_boot: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        !int_rst_n_reg && flash_secured_in |=> boot_mode_out == BOOT_RST)
        else $error("secured flash did not force mode 00");

    a_wake_async: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        low_power_in && !ext_irq_a_n_in |-> irq_wake_out)
        else $error("wake not raised in low power");

    a_apb_error: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        access && !hit_any |-> pslverr_out && prdata_out == '0)
        else $error("unmapped access not refused");

    a_port_dir: assert property (
        @(posedge clk_sys_in) disable iff (!raw_rst_n)
        wr_en && hit_dir |=> dir_reg == $past(pwdata_in[PE_N-1:0]))
        else $error("direction write not taken");

endmodule : ribp_top

`default_nettype wire

// >>> ribp_pkg.sv
`default_nettype none

package ribp_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int unsigned APB_DW   = 32;   // apb data width
    localparam int unsigned APB_AW   = 32;   // apb address width
    localparam int unsigned DEC_W    = 8;    // decoded address bits

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PULLUP_DIS  = 8'h00; // pullup_disable_reg
    localparam logic [7:0] OFS_PE_PULLUP   = 8'h04; // port_e_pullup_enable
    localparam logic [7:0] OFS_PE_FUNC     = 8'h08; // 1 = port, 0 = timer
    localparam logic [7:0] OFS_PE_DIR      = 8'h0c; // 1 = output
    localparam logic [7:0] OFS_PE_DATA     = 8'h10; // out latch / pin read
    localparam logic [7:0] OFS_IRQ_CTRL    = 8'h14; // 1 = falling edge
    localparam logic [7:0] OFS_STATUS      = 8'h18; // pending w1c, boot

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int unsigned PUD_W          = 4;
    localparam int unsigned PUD_IRQ_BIT    = 0;  // irq inputs pull-up off
    localparam int unsigned PUD_RESET_BIT  = 1;  // reset input pull-up off
    localparam int unsigned PUD_BOOT_BIT   = 2;  // boot_strap_pullup_off
    localparam int unsigned PUD_MEMMD_BIT  = 3;  // memory-mode strap off
    localparam int unsigned PE_N           = 4;  // shared timer pins
    localparam int unsigned IRQ_N          = 2;  // ext_irq_a_n, ext_irq_b_n
    localparam int unsigned ST_PEND_LSB    = 0;  // two pending flags
    localparam int unsigned ST_BOOT_LSB    = 2;  // boot mode {mb, ma}
    localparam int unsigned ST_MEMMD_BIT   = 4;  // external memory mode
    localparam int unsigned ST_W           = 5;

    // ------------------------------------------------------------
    // reset values and ties
    // ------------------------------------------------------------
    localparam logic [PUD_W-1:0] PUD_RST      = 4'h0;
    localparam logic [PE_N-1:0]  PE_PULLUP_RST = 4'hf;
    localparam logic [PE_N-1:0]  PE_FUNC_RST  = 4'h0;
    localparam logic [PE_N-1:0]  PE_DIR_RST   = 4'h0;
    localparam logic [PE_N-1:0]  PE_DATA_RST  = 4'h0;
    localparam logic [IRQ_N-1:0] IRQ_CTRL_RST = 2'h0;
    localparam logic [1:0]       BOOT_RST     = 2'h0;
    localparam logic             IRQ_IDLE     = 1'b1;
    localparam logic             EXT_BOOT_TIE = 1'b0;
    localparam logic             MEMMD_TIE    = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned RELEASE_CYCLES_DEF = 32;

    // reset sequencer states
    typedef enum logic [0:0] {
        RST_COUNT,
        RST_DONE
    } ribp_rst_state_t;

endpackage : ribp_pkg

`default_nettype wire

// >>> ribp_irq_if.sv
`default_nettype none

// ------------------------------------------------------------
// control path between the top and one irq channel
// ------------------------------------------------------------
interface ribp_irq_if;
    logic edge_sel;   // 1 = falling edge, 0 = low level
    logic clear;      // one-cycle clear of the pending flag
    logic pending;    // edge pending flag
    logic request;    // service request towards the core

    modport ctrl (output edge_sel, output clear,
                  input pending, input request);
    modport chan (input edge_sel, input clear,
                  output pending, output request);
endinterface : ribp_irq_if

`default_nettype wire

// >>> ribp_irq_chan.sv
`default_nettype none

module ribp_irq_chan (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // request pin, active low
    input  wire logic irq_n_in,
    // control from the top
    ribp_irq_if.chan  ctl
);
    import ribp_pkg::*;

    // ------------------------------------------------------------
    // synchroniser and edge detect
    // ------------------------------------------------------------
    logic meta_reg;   // first stage, read only by sync_reg
    logic sync_reg;   // second stage
    logic prev_reg;   // delayed copy for edge detect
    logic pend_reg;   // falling edge seen
    logic pend_next;
    logic fall;

    // two-flop synchroniser before any detection
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= IRQ_IDLE;
            sync_reg <= IRQ_IDLE;
            prev_reg <= IRQ_IDLE;
        end
        else
        begin
            meta_reg <= irq_n_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // falling edge of the synchronised level
    assign fall = prev_reg & ~sync_reg;

    // set wins over clear; flag only lives in edge mode
    assign pend_next = (ctl.edge_sel & fall)
                     | (pend_reg & ~ctl.clear & ctl.edge_sel);

    // pending flag
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            pend_reg <= 1'b0;
        else
            pend_reg <= pend_next;
    end

    // level mode requests while low, edge mode while pending
    assign ctl.pending = pend_reg;
    assign ctl.request = ctl.edge_sel ? pend_reg : ~sync_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_edge_latch: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        ctl.edge_sel && $fell(sync_reg) |=> ctl.pending)
        else $error("falling edge not latched");

    a_level_sync: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        !ctl.edge_sel && $past(rst_n_in, 2)
            && $past(irq_n_in, 2) == 1'b0 |-> ctl.request)
        else $error("level request not two cycles after pin");

    a_clear_pend: assert property (
        @(posedge clk_in) disable iff (!rst_n_in)
        ctl.clear && !fall |=> !ctl.pending)
        else $error("pending flag survived clear");

endmodule : ribp_irq_chan

`default_nettype wire

// >>> ribp_partner.sv
`default_nettype none

// ------------------------------------------------------------
// far side: reset source and interrupting devices
// ------------------------------------------------------------
module ribp_partner (
    // clock
    input  wire logic       clk_in,
    // pins towards the device
    output var  logic       reset_n_out,
    output var  logic       por_n_out,
    output var  logic       tst_reset_n_out,
    output var  logic [1:0] irq_n_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // board holds reset and test reset from power-up; irq lines idle high
    initial
    begin
        reset_n_out = 1'b0;
        por_n_out = 1'b1;
        tst_reset_n_out = 1'b0;
        irq_n_out = 2'h3;
    end

    // hold a reset for n edges; test reset kept off when debugging
    task automatic hw_reset(input int n, input bit dbg, input bit pwr);
        @(posedge clk_in);
        if (pwr)
            por_n_out <= 1'b0;
        else
            reset_n_out <= 1'b0;
        tst_reset_n_out <= dbg;
        repeat (n) @(posedge clk_in);
        reset_n_out <= 1'b1;
        por_n_out <= 1'b1;
        tst_reset_n_out <= 1'b1;
    endtask : hw_reset

    // one interrupting device moves its request line
    task automatic irq(input int i, input logic v);
        @(posedge clk_in);
        irq_n_out[i] <= v;
    endtask : irq
endmodule : ribp_partner

`default_nettype wire

// >>> ribp_top_tb_top.sv
`default_nettype none

module ribp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ribp_pkg::*;
    logic clk = 0, rst_n, por_n, tst_n, lp = 0, sec = 0, psel = 0;
    logic pen = 0, pw = 0, rdy, serr, ro_n, sr_n, wk, bm_x, pi_a, pu_r;
    logic pu_b, pu_m, mm;
    logic [31:0] pa = 0, pd = 0, pr, r;
    logic [1:0]  irq_n, req, bm;
    logic [3:0]  tdo = 4'h6, tde = 4'h9, pin = 0, pout, poe, ppu, tdi;
    logic        e;
    int          err_total = 0, n_checks = 0, cyc = 0;

    initial forever #2 clk = ~clk;

    ribp_partner p (.clk_in(clk), .reset_n_out(rst_n), .por_n_out(por_n),
        .tst_reset_n_out(tst_n), .irq_n_out(irq_n));

    ribp_top #(.RELEASE_CYCLES(4)) i_dut (.clk_sys_in(clk),
        .reset_n_in(rst_n), .por_n_in(por_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pw), .paddr_in(pa), .pwdata_in(pd),
        .prdata_out(pr), .pready_out(rdy), .pslverr_out(serr),
        .reset_out_n_out(ro_n), .sys_reset_n_out(sr_n),
        .ext_irq_a_n_in(irq_n[0]), .ext_irq_b_n_in(irq_n[1]),
        .low_power_in(lp), .irq_req_out(req), .irq_wake_out(wk),
        .flash_secured_in(sec), .boot_mode_out(bm), .ext_mem_mode_out(mm),
        .irq_pullup_en_out(pi_a), .reset_pullup_en_out(pu_r),
        .boot_strap_pullup_en_out(pu_b), .mem_mode_pullup_en_out(pu_m),
        .port_e_pullup_en_out(ppu), .timer_d_out_in(tdo),
        .timer_d_oe_in(tde), .timer_d_in_out(tdi),
        .timer_d_channel_pins_in(pin), .timer_d_channel_pins_out(pout),
        .timer_d_channel_pins_oe_out(poe));

    // compare and count
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp)
        begin
            $display("BAD %0t %s got %h", $time, m, got);
            err_total++;
        end
    endtask : chk

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1;
        pen <= 0;
        pw <= w;
        pa <= a;
        pd <= d;
        @(posedge clk);
        pen <= 1;
        // wait for pready; only the hang guard ends a stuck wait
        do
        begin
            @(posedge clk);
        end while (rdy !== 1'b1);
        r = pr;
        e = serr;
        psel <= 0;
        pen <= 0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(0, {24'h0, a}, 0);
        chk(r, x, "read");
    endtask : rd

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            end_of_test();
        end
    end

    initial
    begin
        p.hw_reset(12, 0, 0);
        repeat (3) @(posedge clk);
        #1 chk(ro_n, 0, "early release");
        @(posedge clk);
        #1 chk({ro_n, sr_n}, 2'h3, "release");
        chk({pi_a, pu_r, pu_b, pu_m, ppu}, 8'hff, "pullups");
        chk({mm, bm}, 3'h2, "boot");
        chk({poe, pout}, {tde, tdo}, "timer pins");
        rd(OFS_PE_FUNC, 0);
        $display("test reset done");
        apb(1, OFS_PE_FUNC, 32'hf);
        apb(1, OFS_PE_DIR, 32'h5);
        apb(1, OFS_PE_DATA, 32'h3);
        pin <= 4'hb;
        #1 chk({poe, pout & 4'h5}, 8'h51, "port out");
        chk(tdi, 4'hb, "timer in");
        rd(OFS_PE_DATA, 32'hb);
        apb(1, OFS_PE_PULLUP, 0);
        apb(1, OFS_PULLUP_DIS, 32'hf);
        #1 chk({pi_a, pu_r, pu_b, pu_m, ppu}, 0, "pull off");
        $display("test port done");
        p.irq(0, 0);
        @(posedge clk);
        #1 chk(req, 0, "sync");
        @(posedge clk);
        #1 chk(req, 2'h1, "level");
        p.irq(0, 1);
        apb(1, OFS_IRQ_CTRL, 32'h3);
        p.irq(1, 0);
        p.irq(1, 1);
        repeat (4) @(posedge clk);
        #1 chk(req, 2'h2, "edge");
        rd(OFS_STATUS, 32'ha);
        apb(1, OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h8);
        lp <= 1;
        p.irq(0, 0);
        #1 chk(wk, 1, "wake");
        $display("test irq done");
        rd(8'h1c, 0);
        chk(e, 1, "unmapped");
        p.hw_reset(5, 1, 0);
        #1 chk({ro_n, sr_n, poe}, {2'h0, tde}, "pin reset");
        repeat (5) @(posedge clk);
        apb(1, OFS_PE_FUNC, 32'hf);
        sec <= 1;
        #1 chk(poe, 4'h0, "dir after reset");
        p.hw_reset(5, 0, 1);
        #1 chk({ro_n, poe}, {1'b0, tde}, "por");
        repeat (5) @(posedge clk);
        #1 chk(bm, 0, "secured");
        $display("test secured done");
        end_of_test();
    end
endmodule : ribp_top_tb_top

`default_nettype wire
